// file: gpm_board_model.sv
// Board side of the pads: a pull-up on every pad, devices drive only released pads
module gpm_board_model (
    // Design side
    input wire [22:0] pin_out_i,
    input wire [22:0] pin_oe_n_i,
    // Board devices
    input wire [22:0] dev_en_i,
    input wire [22:0] dev_val_i,
    // Resolved pad level
    output wire [22:0] pad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released, undriven pad reads high through its pull-up
    assign pad_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & dev_en_i & dev_val_i) | (pin_oe_n_i & ~dev_en_i);
endmodule

// file: gpm_defines.vh
`ifndef GPM_DEFINES_VH
`define GPM_DEFINES_VH
// Register offsets on the controller register port
`define GPM_ADDR_W 10
`define GPM_OFS_TEST_SEL 10'h1E6
`define GPM_OFS_TEST_EN 10'h1E7
// Own register offsets for the pin controls
`define GPM_OFS_OUT_LO 10'h1C0
`define GPM_OFS_OUT_MID 10'h1C1
`define GPM_OFS_OUT_HI 10'h1C2
`define GPM_OFS_DIR_LO 10'h1C4
`define GPM_OFS_DIR_MID 10'h1C5
`define GPM_OFS_DIR_HI 10'h1C6
`define GPM_OFS_OD_LO 10'h1C8
`define GPM_OFS_OD_MID 10'h1C9
`define GPM_OFS_OD_HI 10'h1CA
`define GPM_OFS_IN_LO 10'h1CC
`define GPM_OFS_IN_MID 10'h1CD
`define GPM_OFS_IN_HI 10'h1CE
`define GPM_OFS_ALT_LO 10'h1D0
`define GPM_OFS_ALT_MID 10'h1D1
`define GPM_OFS_ALT_HI 10'h1D2
`define GPM_OFS_GPO 10'h1D4
`define GPM_OFS_BOOT_LO 10'h1D8
`define GPM_OFS_BOOT_HI 10'h1D9
// Widths
`define GPM_NIO 23
`define GPM_NGPO 8
// Reset values
`define GPM_RST_TEST_SEL 8'h00
`define GPM_RST_TEST_EN 8'h00
`define GPM_RST_BYTE 8'h00
`define GPM_RST_BOOT 16'h0000
// Field positions
`define GPM_TEST_EN_GPO_BIT 2
`define GPM_BOOT_DDC_SEL_BIT 12
`define GPM_BOOT_BAUD_HI_BIT 11
`define GPM_BOOT_BAUD_LO_BIT 10
// Pin indices with alternate functions
`define GPM_PIN_UART_RX 4
`define GPM_PIN_UART_TX 5
`define GPM_PIN_TIMER 3
`define GPM_PIN_EXT_IRQ 8
`define GPM_PIN_FLASH_WE 11
`define GPM_PIN_NVM_SDA 12
`define GPM_PIN_NVM_SCL 13
`define GPM_PIN_DDC_SCL 14
`define GPM_PIN_DDC_SDA 15
`define GPM_PIN_HOST_SDA 16
`define GPM_PIN_IRQ_OUT 21
`define GPM_PIN_HOST_SCL 22
`endif

// file: gpm_pin_mux.v
`include "gpm_defines.vh"
// Operation
// - 23 bidirectional and 8 output-only pins
// - Per-pin direction, open-drain, read and write
// - Output pins general only when test select is 00 and enable bit 2 set
// - Boot select swaps host and DDC pairs
// - Latch bootstrap pins at reset release
// - Baud select from bootstrap bits 11,10
// - Code 00 gives 115.2K, else 57.6K
// - Pins 0-2 carry PWM backlight outputs
// - Pin 3 feeds timer 1 count input
// - Pins 4,5 are UART receive and transmit
// - Pin 8 is active-low external interrupt
// - Pin 21 carries controller interrupt output
// - Pin 11 carries flash write strobe
// - Pins 12,13 are NVRAM serial data, clock
// - Pin 22 host clock, pin 16 host data
// - External ROM fetches every cycle, controller clock
module gpm_pin_mux (
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Controller register port
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [9:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // Bidirectional pins, oe low means driven
    input wire [22:0] pin_in_i,
    output reg [22:0] pin_out_o,
    output reg [22:0] pin_oe_n_o,
    // Output-only pins and test bus
    input wire [7:0] test_bus_i,
    output reg [7:0] gpo_pin_o,
    // ROM address pins sampled at reset release
    input wire [15:0] rom_addr_pins_i,
    // Alternate function engines
    input wire [2:0] pwm_i,
    input wire uart_tx_i,
    input wire ctl_irq_n_i,
    input wire flash_we_n_i,
    input wire nvm_sda_out_i,
    input wire nvm_scl_out_i,
    input wire host_sda_out_i,
    input wire ddc_scl_out_i,
    input wire ddc_sda_out_i,
    output reg timer1_count_o,
    output reg uart_rx_o,
    output reg ext_irq_n_o,
    output reg nvm_sda_in_o,
    output reg host_scl_in_o,
    output reg host_sda_in_o,
    output reg ddc_scl_in_o,
    output reg ddc_sda_in_o,
    // Bootstrap results
    output reg ddc_pin_pair_select_o,
    output reg baud_115k_o
);
    reg [7:0] test_sel_r; // Test output select
    reg [7:0] test_en_r; // Test output enable control
    reg [22:0] out_r; // Output values
    reg [22:0] dir_r; // 1 = output
    reg [22:0] od_r; // 1 = open drain
    reg [22:0] alt_r; // 1 = alternate function enabled
    reg [7:0] gpo_r; // Output-only values
    reg [15:0] boot_r; // Captured bootstrap word
    reg boot_pend_r; // High until first edge after reset release
    wire [22:0] pin_sync; // Synchronised pin levels
    wire [15:0] rom_sync; // Synchronised bootstrap pins
    reg [22:0] alt_on; // Alternate function actually in force
    reg [22:0] alt_out; // Alternate output value
    reg [22:0] alt_drv; // Alternate drives the pin
    reg [22:0] drv_nxt; // Final drive enable
    reg [22:0] val_nxt; // Final output value
    reg [7:0] rd_nxt; // Read data mux
    reg ddc_sel; // Current pair select
    integer i;

    // Pin inputs pass two flops before use
    gpm_sync2 #(.W(23)) u_pin_sync (
        .clk_i(clk_i),
        .d_i(pin_in_i),
        .q_o(pin_sync)
    );
    // Strap synchroniser runs through reset so capture sees real levels
    gpm_sync2 #(.W(16)) u_rom_sync (
        .clk_i(clk_i),
        .d_i(rom_addr_pins_i),
        .q_o(rom_sync)
    );

    // Register writes; bootstrap captured once after release
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            test_sel_r <= `GPM_RST_TEST_SEL;
            test_en_r <= `GPM_RST_TEST_EN;
            out_r <= 23'h000000;
            dir_r <= 23'h000000;
            od_r <= 23'h000000;
            alt_r <= 23'h000000;
            gpo_r <= `GPM_RST_BYTE;
            boot_r <= `GPM_RST_BOOT;
            boot_pend_r <= 1'b1;
        end else begin
            // Straps crossed the synchroniser during reset; latch on first edge
            if (boot_pend_r) begin
                boot_r <= rom_sync;
                boot_pend_r <= 1'b0;
            end
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `GPM_OFS_TEST_SEL: test_sel_r <= reg_wdata_i;
                    `GPM_OFS_TEST_EN: test_en_r <= reg_wdata_i;
                    `GPM_OFS_OUT_LO: out_r[7:0] <= reg_wdata_i;
                    `GPM_OFS_OUT_MID: out_r[15:8] <= reg_wdata_i;
                    `GPM_OFS_OUT_HI: out_r[22:16] <= reg_wdata_i[6:0];
                    `GPM_OFS_DIR_LO: dir_r[7:0] <= reg_wdata_i;
                    `GPM_OFS_DIR_MID: dir_r[15:8] <= reg_wdata_i;
                    `GPM_OFS_DIR_HI: dir_r[22:16] <= reg_wdata_i[6:0];
                    `GPM_OFS_OD_LO: od_r[7:0] <= reg_wdata_i;
                    `GPM_OFS_OD_MID: od_r[15:8] <= reg_wdata_i;
                    `GPM_OFS_OD_HI: od_r[22:16] <= reg_wdata_i[6:0];
                    `GPM_OFS_ALT_LO: alt_r[7:0] <= reg_wdata_i;
                    `GPM_OFS_ALT_MID: alt_r[15:8] <= reg_wdata_i;
                    `GPM_OFS_ALT_HI: alt_r[22:16] <= reg_wdata_i[6:0];
                    `GPM_OFS_GPO: gpo_r <= reg_wdata_i;
                    default: ; // Unmapped writes ignored
                endcase
            end
        end
    end

    // Alternate function routing per pin
    always @* begin
        ddc_sel = boot_r[`GPM_BOOT_DDC_SEL_BIT];
        alt_on = alt_r;
        alt_out = 23'h000000;
        alt_drv = 23'h000000;
        // Host and DDC pairs follow the bootstrap select, not the alt bits
        alt_on[`GPM_PIN_HOST_SCL] = ddc_sel;
        alt_on[`GPM_PIN_HOST_SDA] = ddc_sel;
        alt_on[`GPM_PIN_DDC_SCL] = ~ddc_sel;
        alt_on[`GPM_PIN_DDC_SDA] = ~ddc_sel;
        alt_out[2:0] = pwm_i;
        alt_drv[2:0] = 3'h7;
        alt_out[`GPM_PIN_UART_TX] = uart_tx_i;
        alt_drv[`GPM_PIN_UART_TX] = 1'b1;
        alt_out[`GPM_PIN_IRQ_OUT] = ctl_irq_n_i;
        alt_drv[`GPM_PIN_IRQ_OUT] = 1'b1;
        alt_out[`GPM_PIN_FLASH_WE] = flash_we_n_i;
        alt_drv[`GPM_PIN_FLASH_WE] = 1'b1;
        // Two-wire lines only pull low, as open drain
        alt_drv[`GPM_PIN_NVM_SDA] = ~nvm_sda_out_i;
        alt_drv[`GPM_PIN_NVM_SCL] = ~nvm_scl_out_i;
        alt_drv[`GPM_PIN_HOST_SDA] = ~host_sda_out_i;
        alt_drv[`GPM_PIN_DDC_SCL] = ~ddc_scl_out_i;
        alt_drv[`GPM_PIN_DDC_SDA] = ~ddc_sda_out_i;
        // Timer, UART rx, ext irq and host clock are inputs: no drive
        for (i = 0; i < `GPM_NIO; i = i + 1) begin
            if (alt_on[i]) begin
                val_nxt[i] = alt_out[i];
                drv_nxt[i] = alt_drv[i];
            end else begin
                val_nxt[i] = out_r[i];
                // Open drain drives only a low
                drv_nxt[i] = dir_r[i] & ~(od_r[i] & out_r[i]);
            end
        end
    end

    // Register read mux
    always @* begin
        case (reg_addr_i)
            `GPM_OFS_TEST_SEL: rd_nxt = test_sel_r;
            `GPM_OFS_TEST_EN: rd_nxt = test_en_r;
            `GPM_OFS_OUT_LO: rd_nxt = out_r[7:0];
            `GPM_OFS_OUT_MID: rd_nxt = out_r[15:8];
            `GPM_OFS_OUT_HI: rd_nxt = {1'b0, out_r[22:16]};
            `GPM_OFS_DIR_LO: rd_nxt = dir_r[7:0];
            `GPM_OFS_DIR_MID: rd_nxt = dir_r[15:8];
            `GPM_OFS_DIR_HI: rd_nxt = {1'b0, dir_r[22:16]};
            `GPM_OFS_OD_LO: rd_nxt = od_r[7:0];
            `GPM_OFS_OD_MID: rd_nxt = od_r[15:8];
            `GPM_OFS_OD_HI: rd_nxt = {1'b0, od_r[22:16]};
            `GPM_OFS_IN_LO: rd_nxt = pin_sync[7:0];
            `GPM_OFS_IN_MID: rd_nxt = pin_sync[15:8];
            `GPM_OFS_IN_HI: rd_nxt = {1'b0, pin_sync[22:16]};
            `GPM_OFS_ALT_LO: rd_nxt = alt_r[7:0];
            `GPM_OFS_ALT_MID: rd_nxt = alt_r[15:8];
            `GPM_OFS_ALT_HI: rd_nxt = {1'b0, alt_r[22:16]};
            `GPM_OFS_GPO: rd_nxt = gpo_r;
            `GPM_OFS_BOOT_LO: rd_nxt = boot_r[7:0];
            `GPM_OFS_BOOT_HI: rd_nxt = boot_r[15:8];
            default: rd_nxt = 8'h00; // Unmapped reads zero
        endcase
    end

    // Registered pin and function outputs
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
            pin_out_o <= 23'h000000;
            pin_oe_n_o <= 23'h7FFFFF; // All released during reset
            gpo_pin_o <= 8'h00;
            timer1_count_o <= 1'b0;
            uart_rx_o <= 1'b1;
            ext_irq_n_o <= 1'b1;
            nvm_sda_in_o <= 1'b1;
            host_scl_in_o <= 1'b1;
            host_sda_in_o <= 1'b1;
            ddc_scl_in_o <= 1'b1;
            ddc_sda_in_o <= 1'b1;
            ddc_pin_pair_select_o <= 1'b0;
            baud_115k_o <= 1'b0;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_nxt : 8'h00;
            pin_out_o <= val_nxt;
            pin_oe_n_o <= ~drv_nxt;
            // Test bus owns the pads unless both controls agree
            if (test_sel_r == 8'h00 && test_en_r[`GPM_TEST_EN_GPO_BIT]) begin
                gpo_pin_o <= gpo_r;
            end else begin
                gpo_pin_o <= test_bus_i;
            end
            // Inputs read only when function is enabled; idle level otherwise
            timer1_count_o <= alt_r[`GPM_PIN_TIMER] & pin_sync[`GPM_PIN_TIMER];
            uart_rx_o <= ~alt_r[`GPM_PIN_UART_RX] | pin_sync[`GPM_PIN_UART_RX];
            ext_irq_n_o <= ~alt_on[`GPM_PIN_EXT_IRQ] | pin_sync[`GPM_PIN_EXT_IRQ];
            nvm_sda_in_o <= ~alt_r[`GPM_PIN_NVM_SDA] | pin_sync[`GPM_PIN_NVM_SDA];
            host_scl_in_o <= ~alt_on[`GPM_PIN_HOST_SCL] | pin_sync[`GPM_PIN_HOST_SCL];
            host_sda_in_o <= ~alt_on[`GPM_PIN_HOST_SDA] | pin_sync[`GPM_PIN_HOST_SDA];
            ddc_scl_in_o <= ~alt_on[`GPM_PIN_DDC_SCL] | pin_sync[`GPM_PIN_DDC_SCL];
            ddc_sda_in_o <= ~alt_on[`GPM_PIN_DDC_SDA] | pin_sync[`GPM_PIN_DDC_SDA];
            ddc_pin_pair_select_o <= ddc_sel;
            // Only code 00 is the fast rate
            baud_115k_o <= ~(boot_r[`GPM_BOOT_BAUD_HI_BIT] | boot_r[`GPM_BOOT_BAUD_LO_BIT]);
        end
    end
    // External ROM fetch timing lives in the controller clock domain;
    // this block adds no wait states on that path.
endmodule

// file: gpm_pin_mux_bench.sv
`include "gpm_defines.vh"
module gpm_pin_mux_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // Design inputs, all driven at the falling edge
    logic clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    logic [9:0] reg_addr_i = '0;
    logic [7:0] reg_wdata_i = '0, test_bus_i = '0;
    logic [15:0] rom_addr_pins_i = '0;
    logic [2:0] pwm_i = '0;
    logic uart_tx_i = 1, ctl_irq_n_i = 1, flash_we_n_i = 1, nvm_sda_out_i = 1, nvm_scl_out_i = 1;
    logic host_sda_out_i = 1, ddc_scl_out_i = 1, ddc_sda_out_i = 1;
    logic [22:0] dev_en = '0, dev_val = '0;
    // Design outputs and board-driven pad levels
    wire [7:0] reg_rdata_o, gpo_pin_o;
    wire [22:0] pin_in_i, pin_out_o, pin_oe_n_o;
    wire timer1_count_o, uart_rx_o, ext_irq_n_o, nvm_sda_in_o, host_scl_in_o, host_sda_in_o;
    wire ddc_scl_in_o, ddc_sda_in_o, ddc_pin_pair_select_o, baud_115k_o;
    int failures = 0, comparisons = 0;
    initial forever #5 clk_i = ~clk_i;
    gpm_pin_mux DUT (.*);
    gpm_board_model u_board (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o), .dev_en_i(dev_en),
        .dev_val_i(dev_val), .pad_o(pin_in_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // One write, taken at the rising edge in between
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        @(negedge clk_i);
        reg_wr_i = 0;
    endtask
    // Read data stands for the one cycle after the read edge
    task automatic rdc(input logic [9:0] a, input logic [7:0] e);
        @(negedge clk_i);
        {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(negedge clk_i);
        reg_rd_i = 0;
        chk(reg_rdata_o, e);
    endtask
    // Straps held well before and after release so capture is clean
    task automatic rst(input logic [15:0] s);
        @(negedge clk_i);
        rom_addr_pins_i = s;
        reset_i = 1;
        wt(4);
        reset_i = 0;
        wt(3);
    endtask
    task automatic t_gpo();
        rdc(`GPM_OFS_TEST_SEL, 8'h00);
        rdc(`GPM_OFS_TEST_EN, 8'h00);
        test_bus_i = 8'h3C;
        wr(`GPM_OFS_GPO, 8'h81);
        wr(`GPM_OFS_TEST_EN, 8'h04);
        wt(1);
        chk(gpo_pin_o, 8'h81);
        wr(`GPM_OFS_TEST_SEL, 8'h01);
        wt(1);
        chk(gpo_pin_o, 8'h3C);
        wr(`GPM_OFS_TEST_SEL, 8'h00);
        wr(`GPM_OFS_TEST_EN, 8'hFB);
        wt(1);
        chk(gpo_pin_o, 8'h3C);
        rdc(`GPM_OFS_TEST_EN, 8'hFB);
        rdc(10'h000, 8'h00);
    endtask
    // Low nibble open-drain: only zeros are driven
    task automatic t_gpio();
        wr(`GPM_OFS_DIR_LO, 8'hFF);
        wr(`GPM_OFS_OUT_LO, 8'hA5);
        wr(`GPM_OFS_OD_LO, 8'h0F);
        dev_en = 23'h7F0000;
        dev_val = 23'h2A0000;
        wt(1);
        chk(pin_oe_n_o[7:0], 8'h05);
        chk(pin_out_o[7:4], 4'hA);
        wt(3);
        rdc(`GPM_OFS_IN_LO, 8'hA5);
        rdc(`GPM_OFS_IN_HI, 8'h2A);
        dev_en = '0;
    endtask
    task automatic t_alt();
        logic b;
        wr(`GPM_OFS_ALT_LO, 8'h3F);
        wr(`GPM_OFS_ALT_MID, 8'h39);
        wr(`GPM_OFS_ALT_HI, 8'h20);
        dev_en = 23'h000118;
        for (int v = 0; v < 2; v++) begin
            b = v[0];
            pwm_i = b ? 3'h5 : 3'h2;
            {uart_tx_i, ctl_irq_n_i, flash_we_n_i, nvm_sda_out_i, nvm_scl_out_i} = {b, !b, b, b, !b};
            dev_val = {14'h0, b, 3'h0, !b, b, 3'h0};
            wt(4);
            chk({pin_oe_n_o[2:0], pin_out_o[2:0]}, {3'h0, pwm_i});
            chk(timer1_count_o, b);
            chk({uart_rx_o, pin_out_o[5], pin_oe_n_o[5]}, {!b, b, 1'b0});
            chk(ext_irq_n_o, b);
            chk({pin_out_o[21], pin_oe_n_o[21]}, {!b, 1'b0});
            chk({pin_out_o[11], pin_oe_n_o[11]}, {b, 1'b0});
            chk({pin_oe_n_o[13:12], nvm_sda_in_o}, {!b, b, b});
            chk(pin_oe_n_o[4:3], 2'b11);
        end
    endtask
    // Every baud code, each with the pair select following its low bit
    task automatic t_boot();
        logic [15:0] s;
        {host_sda_out_i, ddc_scl_out_i} = 2'b00;
        dev_en = 23'h408000;
        dev_val = '0;
        for (int k = 0; k < 4; k++) begin
            s = {3'b000, k[0], k[1:0], 10'h000};
            rst(s);
            chk({ddc_pin_pair_select_o, baud_115k_o}, {k[0], k == 0});
            chk({pin_oe_n_o[16], pin_oe_n_o[14]}, {!k[0], k[0]});
            wt(2);
            chk({host_scl_in_o, ddc_sda_in_o}, {!k[0], k[0]});
            chk({host_sda_in_o, ddc_scl_in_o}, {!k[0], k[0]});
            rdc(`GPM_OFS_BOOT_HI, s[15:8]);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        rst(16'h0000);
        t_gpo();
        t_gpio();
        t_alt();
        t_boot();
        test_done();
    end
endmodule

// file: gpm_pin_mux_props.sv
`include "gpm_defines.vh"
// Checks pin drive and read-back against a shadow of the control bytes
module gpm_pin_mux_props (
    // Clock, reset and register port
    input wire clk_i,
    input wire reset_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [9:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    // Pins and function lines
    input wire [22:0] pin_in_i,
    input wire [22:0] pin_out_o,
    input wire [22:0] pin_oe_n_o,
    input wire [7:0] test_bus_i,
    input wire [7:0] gpo_pin_o,
    input wire [2:0] pwm_i,
    input wire host_sda_out_i,
    input wire ddc_scl_out_i,
    input wire timer1_count_o,
    input wire ddc_pin_pair_select_o,
    input wire baud_115k_o
);
    // Shadow bytes, updated on the same edge as the design's own
    logic [7:0] sel_r, en_r, alt_r, dir_r, od_r, out_r;
    // Edges since reset; boot outputs settle by the second
    logic [1:0] cnt_r;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            {sel_r, en_r, alt_r, dir_r, od_r, out_r, cnt_r} <= '0;
        end else begin
            cnt_r <= cnt_r + {1'b0, cnt_r != 2'd3};
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `GPM_OFS_TEST_SEL: sel_r <= reg_wdata_i;
                    `GPM_OFS_TEST_EN: en_r <= reg_wdata_i;
                    `GPM_OFS_ALT_LO: alt_r <= reg_wdata_i;
                    `GPM_OFS_DIR_LO: dir_r <= reg_wdata_i;
                    `GPM_OFS_OD_LO: od_r <= reg_wdata_i;
                    `GPM_OFS_OUT_LO: out_r <= reg_wdata_i;
                    default: ;
                endcase
            end
        end
    end
    // Output-only pins are general only in this one setting
    wire gen_w = (sel_r == 8'h00) && en_r[2];
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Timer pad held steady long enough to cross the synchroniser
    sequence s_timer_held;
        (alt_r[3] && $stable(pin_in_i[3])) [*3];
    endsequence
    chk_gpo_test: assert property (!gen_w |=> gpo_pin_o == $past(test_bus_i))
        else $error("output pins not carrying test bus");
    chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    chk_sel_read: assert property (reg_rd_i && reg_addr_i == `GPM_OFS_TEST_SEL |=> reg_rdata_o == $past(sel_r))
        else $error("test select read-back wrong");
    chk_pwm_drive: assert property (alt_r[2:0] == 3'h7 |=> pin_out_o[2:0] == $past(pwm_i) && pin_oe_n_o[2:0] == 3'h0)
        else $error("backlight pins not driven by pwm");
    chk_gpio_drive: assert property (!alt_r[7] && dir_r[7] && !od_r[7] |=> pin_out_o[7] == $past(out_r[7]) && !pin_oe_n_o[7])
        else $error("general pin not driving its value");
    chk_timer_follow: assert property (s_timer_held |=> timer1_count_o == $past(pin_in_i[3]))
        else $error("timer input not following pad");
    chk_boot_hold: assert property (cnt_r == 2'd3 |-> $stable(ddc_pin_pair_select_o) && $stable(baud_115k_o))
        else $error("bootstrap outputs changed after capture");
    chk_boot_read: assert property (cnt_r == 2'd3 && reg_rd_i && reg_addr_i == `GPM_OFS_BOOT_HI |=> reg_rdata_o[4] == ddc_pin_pair_select_o && (reg_rdata_o[3:2] == 2'b00) == baud_115k_o)
        else $error("bootstrap read-back disagrees with outputs");
    chk_ddc_pair: assert property (cnt_r == 2'd3 && !ddc_pin_pair_select_o && !ddc_scl_out_i |=> !pin_oe_n_o[14])
        else $error("ddc clock pin not pulled low");
    chk_host_pair: assert property (cnt_r == 2'd3 && ddc_pin_pair_select_o && !host_sda_out_i |=> !pin_oe_n_o[16])
        else $error("host data pin not pulled low");
endmodule
bind gpm_pin_mux gpm_pin_mux_props u_props (.clk_i(clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o), .test_bus_i(test_bus_i),
    .gpo_pin_o(gpo_pin_o), .pwm_i(pwm_i), .host_sda_out_i(host_sda_out_i), .ddc_scl_out_i(ddc_scl_out_i),
    .timer1_count_o(timer1_count_o), .ddc_pin_pair_select_o(ddc_pin_pair_select_o), .baud_115k_o(baud_115k_o));

// file: gpm_sync2.v
`include "gpm_defines.vh"
// Two-stage synchroniser for a vector of pin levels
module gpm_sync2 #(
    parameter W = 1
) (
    // Clock
    input wire clk_i,
    // Data
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta_r; // First stage, read only by the second
    reg [W-1:0] sync_r; // Second stage, safe to use
    // Plain double flop with no reset: it keeps sampling while reset holds,
    // so bootstrap straps are through both stages at the first edge after release
    always @(posedge clk_i) begin
        meta_r <= d_i;
        sync_r <= meta_r;
    end
    assign q_o = sync_r;
endmodule
